// *** include/mic_pkg.sv ***
// Constants and carrier types for the processor interrupt controller.
// Assumes an 8-bit special function register bus driven by the core.
package mic_pkg;

    // ==========================================================
    // Register addresses and reset values
    localparam logic [7:0] TIMER_IRQ_CONTROL_ADDR = 8'h88;
    localparam logic [7:0] IRQ_ENABLE_TWO_ADDR = 8'h9a;
    localparam logic [7:0] IRQ_ENABLE_ZERO_ADDR = 8'ha8;
    localparam logic [7:0] IRQ_PRIORITY_ZERO_ADDR = 8'ha9;
    localparam logic [7:0] IRQ_ENABLE_ONE_ADDR = 8'hb8;
    localparam logic [7:0] IRQ_PRIORITY_ONE_ADDR = 8'hb9;
    localparam logic [7:0] IRQ_REQUEST_FLAGS_ADDR = 8'hc0;
    localparam logic [7:0] EDGE_POLARITY_CONTROL_ADDR = 8'hc8;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ==========================================================
    // Field positions
    localparam int TC_IT0 = 0;
    localparam int TC_IE0 = 1;
    localparam int TC_IT1 = 2;
    localparam int TC_IE1 = 3;
    localparam int TC_TF0 = 5;
    localparam int TC_TF1 = 7;
    localparam int RF_EXT2 = 1;
    localparam int RF_EXT3 = 2;
    localparam int RF_EXT4 = 3;
    localparam int RF_EXT5 = 4;
    localparam int RF_EXT6 = 5;
    localparam int EP_EXT2 = 5;
    localparam int EP_EXT3 = 6;
    localparam int EN_GLOBAL = 7;

    // ==========================================================
    // Sources, priority groups and vectors
    localparam int NSRC = 11;
    localparam int S_EXT0 = 0;
    localparam int S_TMR0 = 1;
    localparam int S_EXT1 = 2;
    localparam int S_TMR1 = 3;
    localparam int S_SER0 = 4;
    localparam int S_EXT2 = 5;
    localparam int S_EXT3 = 6;
    localparam int S_EXT4 = 7;
    localparam int S_EXT5 = 8;
    localparam int S_EXT6 = 9;
    localparam int S_SER1 = 10;
    // Priority group per source, one bit pair per group.
    localparam logic [NSRC-1:0][2:0] SRC_GROUP = {
        3'd4, 3'd4, 3'd3, 3'd2, 3'd1, 3'd0,
        3'd4, 3'd3, 3'd1, 3'd0, 3'd0};
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam logic [15:0] VEC_STRIDE = 16'h0008;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } mic_sfr_req_t;

    typedef struct packed {
        logic [3:0] pulse;
        logic eeprom;
        logic spi;
        logic xfer;
        logic sec;
        logic min;
        logic alarm;
        logic temp;
    } mic_subflag_t;

endpackage

// *** src/mic_controller.sv ***
// Interrupt controller of the 8-bit processor core: flags, enables,
// priorities and forced long call to a vector.
// Assumes the core supplies a machine-cycle tick, an instruction-end
// strobe and the return-from-interrupt indication, all on ref_clk.
`timescale 1ns/100ps

// Behaviour
// - Eleven sources, four priority levels, each with its own flag.
// - Each source gated by its own enable bit in three enable registers.
// - Seven sources external to the core, numbered zero to six.
// - Taken interrupt vectors to fixed address; only higher priority preempts.
// - Return from interrupt ends current service level.
// - Flags set on condition regardless of enable bit.
// - Flags sampled once per machine cycle; enabled sample marks request active.
// - Active request acknowledged next instruction by forced long call.
// - No acknowledge while equal or higher priority service runs.
// - No acknowledge during return or write to enable or priority registers.
// - Lines for external interrupts 5 and 6 inverted before the core.
// - Interrupts 0 and 1 from pins, programmable polarity, auto-cleared flags.
// - Interrupt 2 merges four engine pulse flags, manually cleared.
// - Interrupt 4 fires when supply status changes, auto-cleared.
// - Interrupt 5 merges EEPROM busy fall and SPI rise, manual flags.
// - Interrupt 6 merges transfer, ticks, alarm, temperature, manual flags.
// - Alarm event when minutes and hours equal their targets.
module mic_controller
    import mic_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Special function register bus.
    input wire mic_sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    // Core sequencer.
    input wire logic mc_tick,
    input wire logic instr_end,
    input wire logic instr_return_from_irq,
    output logic long_call,
    output logic [15:0] long_call_vector,
    output logic [3:0] service_levels,
    // Internal core sources.
    input wire logic timer0_ovf,
    input wire logic timer1_ovf,
    input wire logic serial0_req,
    input wire logic serial1_req,
    // External sources.
    input wire logic pin_irq0,
    input wire logic pin_irq1,
    input wire logic [3:0] engine_pulse,
    input wire logic engine_busy,
    input wire logic [2:0] supply_status,
    input wire logic eeprom_busy,
    input wire logic serial_port_event,
    input wire logic transfer_busy,
    input wire logic second_tick,
    input wire logic minute_tick,
    input wire logic temperature_event,
    input wire logic [7:0] rtc_minutes,
    input wire logic [7:0] rtc_hours,
    input wire logic [7:0] alarm_minutes,
    input wire logic [7:0] alarm_hours,
    // Manually cleared sub-flags.
    input wire mic_subflag_t sub_flag_clr,
    output mic_subflag_t sub_flags
);

    // ==========================================================
    // Registers
    logic [7:0] timer_irq_control_q;
    logic [7:0] irq_enable_zero_q;
    logic [7:0] irq_enable_one_q;
    logic [7:0] irq_enable_two_q;
    logic [7:0] ip0_q;
    logic [7:0] ip1_q;
    logic [7:0] irq_request_flags_q;
    logic [7:0] edge_polarity_control_q;
    logic [7:0] rdata_q;
    mic_subflag_t sub_q;
    logic [NSRC-1:0] sample_q;
    logic [3:0] insvc_q;
    logic blk_q;
    logic call_q;
    logic [15:0] vec_q;
    logic [13:0] prev_q;
    logic [2:0] supply_q;
    logic alarm_q;

    // ==========================================================
    // Register bus decode
    wire wr = sfr_req.wr;
    wire w_timer_irq_control = wr && sfr_req.addr == TIMER_IRQ_CONTROL_ADDR;
    wire w_irq_enable_zero = wr && sfr_req.addr == IRQ_ENABLE_ZERO_ADDR;
    wire w_irq_enable_one = wr && sfr_req.addr == IRQ_ENABLE_ONE_ADDR;
    wire w_irq_enable_two = wr && sfr_req.addr == IRQ_ENABLE_TWO_ADDR;
    wire w_ip0 = wr && sfr_req.addr == IRQ_PRIORITY_ZERO_ADDR;
    wire w_ip1 = wr && sfr_req.addr == IRQ_PRIORITY_ONE_ADDR;
    wire w_irq_request_flags = wr && sfr_req.addr == IRQ_REQUEST_FLAGS_ADDR;
    wire w_edge_polarity_control = wr && sfr_req.addr == EDGE_POLARITY_CONTROL_ADDR;
    wire en_pri_wr = w_irq_enable_zero | w_irq_enable_one | w_irq_enable_two | w_ip0 | w_ip1;

    // ==========================================================
    // Edge detection on raw source lines
    wire alarm_match = rtc_minutes == alarm_minutes
        && rtc_hours == alarm_hours;
    wire [13:0] raw = {alarm_match, temperature_event, minute_tick,
        second_tick, transfer_busy, serial_port_event, eeprom_busy,
        engine_busy, engine_pulse, pin_irq1, pin_irq0};
    wire [13:0] rise = raw & ~prev_q;
    wire [13:0] fall = ~raw & prev_q;

    // Pin polarity: a set select bit means falling edge.
    wire pin0_ev = timer_irq_control_q[TC_IT0] ? fall[0] : rise[0];
    wire pin1_ev = timer_irq_control_q[TC_IT1] ? fall[1] : rise[1];
    // Engine pulse and busy edges follow the polarity selects. The pulse
    // lines reach the core inverted, so the cleared select that software
    // is told to use catches the rising edge of each pulse.
    wire [3:0] pulse_ev = edge_polarity_control_q[EP_EXT2] ? fall[5:2] : rise[5:2];
    wire busy_ev = edge_polarity_control_q[EP_EXT3] ? rise[6] : fall[6];
    wire supply_ev = supply_status != supply_q;

    // Condition events for the manually cleared sub-flags.
    mic_subflag_t sub_set;
    assign sub_set.pulse = pulse_ev;
    assign sub_set.eeprom = fall[7];
    assign sub_set.spi = rise[8];
    assign sub_set.xfer = fall[9];
    assign sub_set.sec = rise[10];
    assign sub_set.min = rise[11];
    assign sub_set.temp = rise[12];
    assign sub_set.alarm = rise[13];

    // The merged lines for interrupts 5 and 6 leave their sources inverted, as the core
    // treats these inputs as active-low levels; the core re-inverts.
    wire ext5_line_n = ~(sub_q.eeprom | sub_q.spi);
    wire ext6_line_n = ~(sub_q.xfer | sub_q.sec | sub_q.min
        | sub_q.alarm | sub_q.temp);
    wire ext2_line = |sub_q.pulse;

    // ==========================================================
    // Request flags, enables and levels
    wire [NSRC-1:0] flags = {serial1_req, ~ext6_line_n, ~ext5_line_n,
        irq_request_flags_q[RF_EXT4], irq_request_flags_q[RF_EXT3], ext2_line, serial0_req,
        timer_irq_control_q[TC_TF1], timer_irq_control_q[TC_IE1], timer_irq_control_q[TC_TF0],
        timer_irq_control_q[TC_IE0]};
    wire [NSRC-1:0] enables = {NSRC{irq_enable_zero_q[EN_GLOBAL]}}
        & {irq_enable_two_q[0], irq_enable_one_q[5:1], irq_enable_zero_q[4:0]};
    wire [NSRC-1:0] active = sample_q & enables;

    // Highest level wins; on a tie the lowest index wins.
    logic [2:0] win_lvl_p1;
    logic [3:0] win_idx;
    always_comb begin
        logic [2:0] lvl;
        lvl = 3'd0;
        win_lvl_p1 = 3'd0;
        win_idx = 4'd0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            lvl = {1'b0, ip1_q[SRC_GROUP[i]], ip0_q[SRC_GROUP[i]]}
                + 3'd1;
            if (active[i] && lvl >= win_lvl_p1) begin
                win_lvl_p1 = lvl;
                win_idx = 4'(i);
            end
        end
    end

    // Running service level, plus one; zero when nothing runs.
    wire [2:0] cur_p1 = insvc_q[3] ? 3'd4 : insvc_q[2] ? 3'd3
        : insvc_q[1] ? 3'd2 : insvc_q[0] ? 3'd1 : 3'd0;
    wire blocked = blk_q | en_pri_wr | instr_return_from_irq;
    wire ack = instr_end && !blocked && win_lvl_p1 > cur_p1;
    wire [NSRC-1:0] ack_vec = ack ? NSRC'(1) << win_idx : '0;
    wire [3:0] lvl_bit = 4'(1) << 2'(win_lvl_p1 - 3'd1);
    wire [3:0] top_bit = 4'(1) << 2'(cur_p1 - 3'd1);
    wire return_from_irq_pop = instr_end && instr_return_from_irq && cur_p1 != 3'd0;

    // ==========================================================
    // Timer control register: pin flags auto-clear on acknowledge,
    // and an event in the clearing cycle still sets the flag.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            timer_irq_control_q <= REG_RESET;
        end else begin
            timer_irq_control_q <= (w_timer_irq_control ? sfr_req.wdata : timer_irq_control_q)
                & ~{ack_vec[S_TMR1], 1'b0, ack_vec[S_TMR0], 1'b0,
                ack_vec[S_EXT1], 1'b0, ack_vec[S_EXT0], 1'b0}
                | {timer1_ovf, 1'b0, timer0_ovf, 1'b0, pin1_ev, 1'b0,
                pin0_ev, 1'b0};
        end
    end

    // Request register: bits 2 and 3 are auto-cleared flags.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            irq_request_flags_q <= REG_RESET;
        end else begin
            irq_request_flags_q <= (w_irq_request_flags ? sfr_req.wdata : irq_request_flags_q)
                & ~{4'h0, ack_vec[S_EXT4], ack_vec[S_EXT3], 2'h0}
                | {4'h0, supply_ev, busy_ev, 2'h0};
        end
    end

    // Enable, priority and polarity registers.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            irq_enable_zero_q <= REG_RESET;
            irq_enable_one_q <= REG_RESET;
            irq_enable_two_q <= REG_RESET;
            ip0_q <= REG_RESET;
            ip1_q <= REG_RESET;
            edge_polarity_control_q <= REG_RESET;
        end else begin
            irq_enable_zero_q <= w_irq_enable_zero ? sfr_req.wdata : irq_enable_zero_q;
            irq_enable_one_q <= w_irq_enable_one ? sfr_req.wdata : irq_enable_one_q;
            irq_enable_two_q <= w_irq_enable_two ? sfr_req.wdata : irq_enable_two_q;
            ip0_q <= w_ip0 ? sfr_req.wdata : ip0_q;
            ip1_q <= w_ip1 ? sfr_req.wdata : ip1_q;
            edge_polarity_control_q <= w_edge_polarity_control ? sfr_req.wdata : edge_polarity_control_q;
        end
    end

    // Manual sub-flags: software clears them, a new event wins.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sub_q <= '0;
        end else begin
            sub_q <= (sub_q & ~sub_flag_clr) | sub_set;
        end
    end

    // Edge history for the source lines.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            prev_q <= '0;
            supply_q <= 3'h0;
        end else begin
            prev_q <= raw;
            supply_q <= supply_status;
        end
    end

    // ==========================================================
    // Sampling once per machine cycle; the acknowledged sample is
    // dropped so a stale copy cannot call the same vector twice.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sample_q <= '0;
        end else begin
            sample_q <= (mc_tick ? flags : sample_q) & ~ack_vec;
        end
    end

    // Blocking window for the instruction now executing.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            blk_q <= 1'b0;
        end else begin
            blk_q <= !instr_end && (blk_q | en_pri_wr | instr_return_from_irq);
        end
    end

    // Service levels: push on acknowledge, pop the top on return.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            insvc_q <= 4'h0;
        end else if (ack) begin
            insvc_q <= insvc_q | lvl_bit;
        end else if (return_from_irq_pop) begin
            insvc_q <= insvc_q & ~top_bit;
        end
    end

    // Forced long call with its vector.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            call_q <= 1'b0;
            vec_q <= 16'h0000;
        end else begin
            call_q <= ack;
            if (ack) begin
                vec_q <= VEC_BASE + 16'(VEC_STRIDE * win_idx);
            end
        end
    end

    // ==========================================================
    // Read data, registered; merged lines read back live.
    wire [7:0] irq_request_flags_rd = {irq_request_flags_q[7:6], ~ext6_line_n, ~ext5_line_n,
        irq_request_flags_q[3:2], ext2_line, irq_request_flags_q[0]};
    logic [7:0] rd_mux;
    always_comb begin
        unique case (sfr_req.addr)
            TIMER_IRQ_CONTROL_ADDR: rd_mux = timer_irq_control_q;
            IRQ_ENABLE_ZERO_ADDR: rd_mux = irq_enable_zero_q;
            IRQ_ENABLE_ONE_ADDR: rd_mux = irq_enable_one_q;
            IRQ_ENABLE_TWO_ADDR: rd_mux = irq_enable_two_q;
            IRQ_PRIORITY_ZERO_ADDR: rd_mux = ip0_q;
            IRQ_PRIORITY_ONE_ADDR: rd_mux = ip1_q;
            IRQ_REQUEST_FLAGS_ADDR: rd_mux = irq_request_flags_rd;
            EDGE_POLARITY_CONTROL_ADDR: rd_mux = edge_polarity_control_q;
            default: rd_mux = UNMAPPED_READ;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rdata_q <= 8'h00;
        end else if (sfr_req.rd) begin
            rdata_q <= rd_mux;
        end
    end

    assign sfr_rdata = rdata_q;
    assign long_call = call_q;
    assign long_call_vector = vec_q;
    assign service_levels = insvc_q;
    assign sub_flags = sub_q;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence s_taken;
        instr_end && !blocked && win_lvl_p1 > cur_p1;
    endsequence

    property p_call_cause;
        long_call |-> $past(instr_end) && $past(active) != '0;
    endproperty
    a_call_cause: assert property (p_call_cause)
        else $error("long call without an active request");

    property p_blocked;
        instr_end && (instr_return_from_irq || en_pri_wr) |=> !long_call;
    endproperty
    a_blocked: assert property (p_blocked)
        else $error("long call during a blocking instruction");

    property p_preempt;
        long_call |-> $past(win_lvl_p1) > $past(cur_p1);
    endproperty
    a_preempt: assert property (p_preempt)
        else $error("equal or lower priority preempted a service");

    property p_vector;
        s_taken |=> long_call_vector
            == VEC_BASE + 16'(VEC_STRIDE * $past(win_idx));
    endproperty
    a_vector: assert property (p_vector)
        else $error("long call vector does not match the winner");

    property p_sample;
        !mc_tick && !ack |=> sample_q == $past(sample_q);
    endproperty
    a_sample: assert property (p_sample)
        else $error("samples changed outside a machine-cycle tick");

    property p_return_from_irq;
        return_from_irq_pop && !ack |=> service_levels == $past(insvc_q & ~top_bit);
    endproperty
    a_return_from_irq: assert property (p_return_from_irq)
        else $error("return did not end the top service level");

    property p_supply;
        supply_status != supply_q |=> irq_request_flags_q[RF_EXT4];
    endproperty
    a_supply: assert property (p_supply)
        else $error("supply change did not set its flag");

    property p_alarm;
        alarm_match && !prev_q[13] |=> sub_flags.alarm;
    endproperty
    a_alarm: assert property (p_alarm)
        else $error("alarm match did not set its flag");

    property p_busy_clear;
        ack_vec[S_EXT3] && !busy_ev ##1 !busy_ev |-> !irq_request_flags_q[RF_EXT3];
    endproperty
    a_busy_clear: assert property (p_busy_clear)
        else $error("engine busy flag not cleared on acknowledge");

endmodule // mic_controller

// *** verif/mic_core_model.sv ***
// Behavioural model of the core sequencer that drives the controller.
// Assumes the controller shares ref_clk and the synchronous reset.
`timescale 1ns/100ps

// ==========================================================
// Sequencer model
module mic_core_model (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Bench request to run a return instruction.
    input wire logic return_from_irq_req,
    // Sequencer strobes.
    output logic mc_tick,
    output logic instr_end,
    output logic instr_return_from_irq
);
    logic [1:0] phase_q;

    // Four-clock instructions keep the run short; only the order of the
    // sample tick and the instruction end matters to the controller.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            phase_q <= 2'h0;
            mc_tick <= 1'b0;
            instr_end <= 1'b0;
        end else begin
            phase_q <= phase_q + 2'h1;
            mc_tick <= (phase_q == 2'h0);
            instr_end <= (phase_q == 2'h2);
        end
    end

    // The return indication is the bench request passed straight through, however the bench times it.
    assign instr_return_from_irq = return_from_irq_req;
endmodule // mic_core_model

// *** verif/testbench.sv ***
// Self-checking bench for the interrupt controller.
// Assumes mic_pkg and the sequencer model mic_core_model.
`timescale 1ns/100ps

module testbench
    import mic_pkg::*;
;
    // ==========================================================
    // Signals
    logic ref_clk, sys_rst, return_from_irq_req, mc_tick, instr_end, instr_return_from_irq;
    mic_sfr_req_t sfr_req;
    logic [7:0] sfr_rdata, rtc_minutes, rtc_hours, alarm_minutes, alarm_hours;
    logic long_call, timer0_ovf, timer1_ovf, serial0_req, serial1_req;
    logic [15:0] long_call_vector;
    logic [3:0] service_levels, engine_pulse;
    logic pin_irq0, pin_irq1, engine_busy, eeprom_busy, serial_port_event;
    logic transfer_busy, second_tick, minute_tick, temperature_event;
    logic [2:0] supply_status;
    mic_subflag_t sub_flag_clr, sub_flags;
    int miscompares, compares, cycles;

    // ==========================================================
    // Instances
    mic_core_model core (.ref_clk, .sys_rst, .return_from_irq_req, .mc_tick,
        .instr_end, .instr_return_from_irq);
    mic_controller dut (.ref_clk, .sys_rst, .sfr_req, .sfr_rdata, .mc_tick,
        .instr_end, .instr_return_from_irq, .long_call, .long_call_vector,
        .service_levels, .timer0_ovf, .timer1_ovf, .serial0_req,
        .serial1_req, .pin_irq0, .pin_irq1, .engine_pulse, .engine_busy,
        .supply_status, .eeprom_busy, .serial_port_event, .transfer_busy,
        .second_tick, .minute_tick, .temperature_event, .rtc_minutes,
        .rtc_hours, .alarm_minutes, .alarm_hours, .sub_flag_clr, .sub_flags);

    // Free-running clock at 100 MHz.
    always #5 ref_clk = ~ref_clk;

    // Cut a hung run short; the tests need well under a thousand cycles.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            finish_test();
        end
    end

    // ==========================================================
    // Shared tasks
    task automatic finish_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk) sfr_req <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk) sfr_req <= '0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk) sfr_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge ref_clk) sfr_req <= '0;
        #1 chk({8'h00, sfr_rdata}, {8'h00, exp});
    endtask

    // Waits a bounded time for the forced call, then checks its target.
    task automatic call_chk(input logic [15:0] vec, input logic [3:0] lv);
        int n;
        n = 0;
        while (n < 40 && long_call !== 1'b1) begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk({15'h0, long_call}, 16'h0001);
        chk(long_call_vector, vec);
        chk({12'h000, service_levels}, {12'h000, lv});
    endtask

    task automatic no_call(input int n);
        logic hit;
        hit = 1'b0;
        repeat (n) begin
            @(posedge ref_clk);
            #1 hit = hit | (long_call === 1'b1);
        end
        chk({15'h0, hit}, 16'h0000);
    endtask

    // Holds the return indication until an instruction end has seen it.
    task automatic ret_chk(input logic [3:0] lv);
        @(posedge ref_clk) return_from_irq_req <= 1'b1;
        do @(posedge ref_clk); while (instr_end !== 1'b1);
        return_from_irq_req <= 1'b0;
        @(posedge ref_clk);
        #1 chk({12'h000, service_levels}, {12'h000, lv});
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_regs();
        logic [7:0] a [8] = '{TIMER_IRQ_CONTROL_ADDR, IRQ_REQUEST_FLAGS_ADDR,
            EDGE_POLARITY_CONTROL_ADDR, IRQ_ENABLE_ZERO_ADDR,
            IRQ_ENABLE_ONE_ADDR, IRQ_ENABLE_TWO_ADDR, IRQ_PRIORITY_ZERO_ADDR,
            IRQ_PRIORITY_ONE_ADDR};
        logic [7:0] v [5] = '{8'h9f, 8'h3e, 8'h01, 8'h1f, 8'h1f};
        foreach (a[i]) rd_chk(a[i], REG_RESET);
        rd_chk(8'h80, UNMAPPED_READ);
        for (int i = 0; i < 5; i++) begin
            wr(a[i + 3], v[i]);
            rd_chk(a[i + 3], v[i]);
            wr(a[i + 3], 8'h00);
        end
        $display("test registers done");
    endtask

    task automatic t_pins();
        @(posedge ref_clk) timer0_ovf <= 1'b1;
        @(posedge ref_clk) timer0_ovf <= 1'b0;
        no_call(20);
        rd_chk(TIMER_IRQ_CONTROL_ADDR, 8'h20);
        wr(TIMER_IRQ_CONTROL_ADDR, 8'h00);
        wr(IRQ_ENABLE_ZERO_ADDR, 8'h81);
        @(posedge ref_clk) pin_irq0 <= 1'b1;
        call_chk(VEC_BASE, 4'h1);
        rd_chk(TIMER_IRQ_CONTROL_ADDR, 8'h00);
        ret_chk(4'h0);
        wr(TIMER_IRQ_CONTROL_ADDR, 8'h01);
        @(posedge ref_clk) pin_irq0 <= 1'b0;
        call_chk(VEC_BASE, 4'h1);
        ret_chk(4'h0);
        wr(TIMER_IRQ_CONTROL_ADDR, 8'h00);
        $display("test pins done");
    endtask

    task automatic t_levels();
        wr(IRQ_ENABLE_ZERO_ADDR, 8'h87);
        @(posedge ref_clk) pin_irq0 <= 1'b1;
        call_chk(VEC_BASE, 4'h1);
        @(posedge ref_clk) timer0_ovf <= 1'b1;
        @(posedge ref_clk) timer0_ovf <= 1'b0;
        no_call(20);
        wr(IRQ_PRIORITY_ZERO_ADDR, 8'h02);
        @(posedge ref_clk) pin_irq1 <= 1'b1;
        call_chk(16'h0013, 4'h3);
        ret_chk(4'h1);
        ret_chk(4'h0);
        call_chk(16'h000b, 4'h1);
        ret_chk(4'h0);
        wr(IRQ_PRIORITY_ZERO_ADDR, 8'h00);
        $display("test levels done");
    endtask

    // A pending request must wait out returns and enable writes.
    task automatic t_block();
        wr(IRQ_ENABLE_ZERO_ADDR, 8'h81);
        @(posedge ref_clk) begin
            pin_irq0 <= 1'b0;
            return_from_irq_req <= 1'b1;
        end
        @(posedge ref_clk) pin_irq0 <= 1'b1;
        no_call(24);
        fork
            repeat (8) wr(IRQ_ENABLE_ZERO_ADDR, 8'h81);
            no_call(16);
            @(posedge ref_clk) return_from_irq_req <= 1'b0;
        join
        call_chk(VEC_BASE, 4'h1);
        ret_chk(4'h0);
        wr(IRQ_ENABLE_ZERO_ADDR, 8'h00);
        $display("test blocking done");
    endtask

    task automatic t_sources();
        wr(EDGE_POLARITY_CONTROL_ADDR, 8'h00);
        @(posedge ref_clk) begin
            engine_pulse <= 4'hf;
            engine_busy <= 1'b1;
            eeprom_busy <= 1'b1;
            serial_port_event <= 1'b1;
            transfer_busy <= 1'b1;
            second_tick <= 1'b1;
            minute_tick <= 1'b1;
            temperature_event <= 1'b1;
            supply_status <= 3'h5;
            rtc_hours <= 8'h12;
        end
        @(posedge ref_clk) begin
            engine_busy <= 1'b0;
            eeprom_busy <= 1'b0;
            transfer_busy <= 1'b0;
        end
        repeat (4) @(posedge ref_clk);
        #1 chk({5'h00, sub_flags}, 16'h07ff);
        rd_chk(IRQ_REQUEST_FLAGS_ADDR, 8'h3e);
        wr(IRQ_ENABLE_ONE_ADDR, 8'h0c);
        wr(IRQ_ENABLE_ZERO_ADDR, 8'h80);
        call_chk(16'h0033, 4'h1);
        ret_chk(4'h0);
        call_chk(16'h003b, 4'h1);
        rd_chk(IRQ_REQUEST_FLAGS_ADDR, 8'h32);
        ret_chk(4'h0);
        wr(IRQ_ENABLE_ZERO_ADDR, 8'h00);
        @(posedge ref_clk) sub_flag_clr <= '1;
        @(posedge ref_clk) sub_flag_clr <= '0;
        #1 chk({5'h00, sub_flags}, 16'h0000);
        wr(IRQ_REQUEST_FLAGS_ADDR, 8'h00);
        rd_chk(IRQ_REQUEST_FLAGS_ADDR, 8'h00);
        $display("test sources done");
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        ref_clk = 1'b0;
        sys_rst = 1'b1;
        return_from_irq_req = 1'b0;
        sfr_req = '0;
        {timer0_ovf, timer1_ovf, serial0_req, serial1_req} = 4'h0;
        {pin_irq0, pin_irq1, engine_busy, eeprom_busy} = 4'h0;
        {serial_port_event, transfer_busy, second_tick} = 3'h0;
        {minute_tick, temperature_event} = 2'h0;
        engine_pulse = 4'h0;
        supply_status = 3'h0;
        {rtc_minutes, rtc_hours, alarm_minutes} = 24'h00_0000;
        alarm_hours = 8'h12;
        sub_flag_clr = '0;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_pins();
        t_levels();
        t_block();
        t_sources();
        finish_test();
    end
endmodule // testbench
